// file: common/tri_params.svh
// timer flag block constants: offsets, field positions, reset values
`ifndef TRI_PARAMS_SVH
`define TRI_PARAMS_SVH
`define TRI_ADDR_W          4
`define TRI_OFF_STATUS_CTRL 4'h0
`define TRI_OFF_CH_CTRL0    4'h1
`define TRI_OFF_CH_CTRL1    4'h2
`define TRI_OFF_CH_FLAGS    4'h3
`define TRI_OFF_MODULO      4'h4
`define TRI_OFF_IRQ_STATUS  4'h5
`define TRI_OFF_IRQ_MASK    4'h6
// status/control fields
`define TRI_SC_OVF_FLAG     7
`define TRI_SC_OVF_IE       6
`define TRI_SC_CENTER       5
`define TRI_SC_CLK_LO       3
`define TRI_SC_CLK_HI       4
`define TRI_SC_RESET        8'h00
// channel control fields
`define TRI_CC_FLAG         7
`define TRI_CC_IE           6
`define TRI_CC_MS_HI        5
`define TRI_CC_MS_LO        4
`define TRI_CC_ELS_HI       3
`define TRI_CC_ELS_LO       2
`define TRI_CC_RESET        8'h00
`define TRI_MOD_RESET       16'h0000
`endif

// file: common/tri_pkg.sv
// timer flag block types
package tri_pkg;
   typedef enum logic [1:0] {
      TRI_CH_CAPTURE = 2'b00,
      TRI_CH_COMPARE = 2'b01,
      TRI_CH_EPWM    = 2'b10,
      TRI_CH_CPWM    = 2'b11
   } tri_ch_mode_t;
   typedef enum logic [1:0] {
      TRI_ARM_IDLE  = 2'b00,
      TRI_ARM_READY = 2'b01
   } tri_arm_t;
endpackage

// file: core/tri_flag_cell.sv
// one event flag with read-then-write-zero clearing
`timescale 1ns/1ns
module tri_flag_cell
   import tri_pkg::*;
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic set_evt,
   input  wire logic rd_seen,
   input  wire logic wr_zero,
   output logic      flag
);
   tri_arm_t arm_reg;

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         arm_reg <= TRI_ARM_IDLE;
      end else if (set_evt) begin
         arm_reg <= TRI_ARM_IDLE;
      end else if (rd_seen && flag) begin
         arm_reg <= TRI_ARM_READY;
      end else if (wr_zero) begin
         arm_reg <= TRI_ARM_IDLE;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         flag <= 1'b0;
      end else if (set_evt) begin
         flag <= 1'b1;
      end else if (wr_zero && arm_reg == TRI_ARM_READY) begin
         flag <= 1'b0;
      end
   end

   property p_clear_needs_arm;
      @(posedge ref_clk) disable iff (!rst_n)
         ($fell(flag)) |-> $past(arm_reg == TRI_ARM_READY && wr_zero);
   endproperty
   a_clear_needs_arm: assert property (p_clear_needs_arm) else $error("flag cleared without armed write");

   property p_event_wins;
      @(posedge ref_clk) disable iff (!rst_n)
         set_evt |=> flag;
   endproperty
   a_event_wins: assert property (p_event_wins) else $error("event lost");
endmodule

// file: core/tri_timer_flags.sv
// timer reset state and interrupt flag logic
//
// Strobed register access and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
`include "tri_params.svh"

// Behaviour
// - reset clears status/control, clock off, no ovf irq
// - reset clears center and channel mode bits
// - one overflow source, one per channel
// - capture edge sets channel flag
// - compare match sets channel flag
// - requests active high, gated by enables
// - level request while flag and enable set
// - clear by read-set then write zero
// - event between read and write cancels clear
// - edge mode overflow at terminal to zero
// - center mode overflow at up-down reversal
// - edge select: off, rise, fall, both
// - edge pwm flag on match
// - center pwm flag on both matches
module tri_timer_flags
   import tri_pkg::*;
#(
   parameter int N_CH = 2
)
(
   input  wire logic                   ref_clk,
   input  wire logic                   rst_n,
   input  wire logic [`TRI_ADDR_W-1:0] addr,
   input  wire logic [15:0]            wdata,
   input  wire logic                   wr_stb,
   input  wire logic                   rd_stb,
   output logic      [15:0]            rdata,
   input  wire logic [15:0]            count,
   input  wire logic [N_CH-1:0]        ch_pin,
   input  wire logic [N_CH*16-1:0]     ch_value,
   output logic                        ovf_irq,
   output logic      [N_CH-1:0]        ch_irq,
   output logic                        irq,
   output logic      [7:0]             status_ctrl_out,
   output logic      [N_CH-1:0]        ch_pin_owned
);
   ////////////////////////////////////////////////////////////////////////
   logic rst_meta_reg;
   logic rst_sync_reg;
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_reg <= 1'b0;
         rst_sync_reg <= 1'b0;
      end else begin
         rst_meta_reg <= 1'b1;
         rst_sync_reg <= rst_meta_reg;
      end
   end
   wire logic srst_n = rst_sync_reg;

   ////////////////////////////////////////////////////////////////////////
   logic [7:0]      sc_reg;
   logic [7:0]      cc_reg [N_CH];
   logic [15:0]     mod_reg;
   logic [15:0]     cnt_prev_reg;
   logic            dir_down_reg;
   logic [N_CH-1:0] pin_prev_reg;
   logic            ovf_flag;
   logic [N_CH-1:0] ch_flag;
   logic [N_CH:0]   ist_reg;
   logic [N_CH:0]   imask_reg;

   wire logic wr_sc   = wr_stb && addr == `TRI_OFF_STATUS_CTRL;
   wire logic rd_sc   = rd_stb && addr == `TRI_OFF_STATUS_CTRL;
   wire logic rd_chf  = rd_stb && addr == `TRI_OFF_CH_FLAGS;
   wire logic wr_chf  = wr_stb && addr == `TRI_OFF_CH_FLAGS;

   function automatic logic [`TRI_ADDR_W-1:0] ch_off(input int i);
      ch_off = (i == 0) ? `TRI_OFF_CH_CTRL0 : `TRI_OFF_CH_CTRL1;
   endfunction

   function automatic tri_ch_mode_t ch_mode(input logic [7:0] c, input logic center);
      if (center) ch_mode = TRI_CH_CPWM;
      else if (c[`TRI_CC_MS_HI]) ch_mode = TRI_CH_EPWM;
      else if (c[`TRI_CC_MS_LO]) ch_mode = TRI_CH_COMPARE;
      else ch_mode = TRI_CH_CAPTURE;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // control registers
   always_ff @(posedge ref_clk or negedge srst_n) begin
      if (!srst_n) begin
         sc_reg <= `TRI_SC_RESET;
      end else if (wr_sc) begin
         sc_reg <= {1'b0, wdata[6:0]};
      end
   end

   always_ff @(posedge ref_clk or negedge srst_n) begin
      if (!srst_n) begin
         for (int i = 0; i < N_CH; i++) cc_reg[i] <= `TRI_CC_RESET;
      end else begin
         for (int i = 0; i < N_CH; i++)
            if (wr_stb && addr == ch_off(i)) cc_reg[i] <= {1'b0, wdata[6:0]};
      end
   end

   always_ff @(posedge ref_clk or negedge srst_n) begin
      if (!srst_n) begin
         mod_reg <= `TRI_MOD_RESET;
      end else if (wr_stb && addr == `TRI_OFF_MODULO) begin
         mod_reg <= wdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // event detection
   wire logic center  = sc_reg[`TRI_SC_CENTER];
   wire logic running = sc_reg[`TRI_SC_CLK_HI] | sc_reg[`TRI_SC_CLK_LO];
   wire logic [15:0] term = (mod_reg == 16'h0000) ? 16'hFFFF : mod_reg;

   always_ff @(posedge ref_clk or negedge srst_n) begin
      if (!srst_n) begin
         cnt_prev_reg <= 16'h0000;
         pin_prev_reg <= '0;
         dir_down_reg <= 1'b0;
      end else begin
         cnt_prev_reg <= count;
         pin_prev_reg <= ch_pin;
         // direction of the last count change
         if (count != cnt_prev_reg) dir_down_reg <= count < cnt_prev_reg;
      end
   end

   wire logic cnt_moved = count != cnt_prev_reg;
   logic ovf_evt;
   always_comb begin
      if (center)
         ovf_evt = running && cnt_prev_reg == term && !dir_down_reg && count < cnt_prev_reg;
      else
         ovf_evt = running && cnt_moved && cnt_prev_reg == term && count == 16'h0000;
   end

   logic [N_CH-1:0] ch_evt;
   always_comb begin
      for (int i = 0; i < N_CH; i++) begin
         logic rise;
         logic fall;
         logic match;
         rise  = ch_pin[i] & ~pin_prev_reg[i];
         fall  = ~ch_pin[i] & pin_prev_reg[i];
         match = running && cnt_moved && count == ch_value[i*16 +: 16];
         unique case (ch_mode(cc_reg[i], center))
            TRI_CH_CAPTURE:
               ch_evt[i] = (cc_reg[i][`TRI_CC_ELS_LO] & rise) | (cc_reg[i][`TRI_CC_ELS_HI] & fall);
            TRI_CH_COMPARE: ch_evt[i] = match;
            TRI_CH_EPWM:    ch_evt[i] = match;
            TRI_CH_CPWM:    ch_evt[i] = match;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags, one cell per source
   tri_flag_cell u_ovf (
      .ref_clk (ref_clk),
      .rst_n   (srst_n),
      .set_evt (ovf_evt),
      .rd_seen (rd_sc),
      .wr_zero (wr_sc && !wdata[`TRI_SC_OVF_FLAG]),
      .flag    (ovf_flag)
   );

   for (genvar g = 0; g < N_CH; g++) begin : g_ch
      tri_flag_cell u_ch (
         .ref_clk (ref_clk),
         .rst_n   (srst_n),
         .set_evt (ch_evt[g]),
         .rd_seen (rd_chf || (rd_stb && addr == ch_off(g))),
         .wr_zero ((wr_chf && !wdata[g]) || (wr_stb && addr == ch_off(g) && !wdata[`TRI_CC_FLAG])),
         .flag    (ch_flag[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // sticky status and mask for the summary line
   wire logic [N_CH:0] src_evt = {ch_evt, ovf_evt};
   always_ff @(posedge ref_clk or negedge srst_n) begin
      if (!srst_n) begin
         ist_reg <= '0;
      end else begin
         ist_reg <= src_evt | (ist_reg & ~((wr_stb && addr == `TRI_OFF_IRQ_STATUS) ? wdata[N_CH:0] : '0));
      end
   end

   always_ff @(posedge ref_clk or negedge srst_n) begin
      if (!srst_n) begin
         imask_reg <= '0;
      end else if (wr_stb && addr == `TRI_OFF_IRQ_MASK) begin
         imask_reg <= wdata[N_CH:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs, all registered
   logic [N_CH-1:0] ch_req;
   always_comb begin
      for (int i = 0; i < N_CH; i++) ch_req[i] = ch_flag[i] & cc_reg[i][`TRI_CC_IE];
   end

   always_ff @(posedge ref_clk or negedge srst_n) begin
      if (!srst_n) begin
         ovf_irq         <= 1'b0;
         ch_irq          <= '0;
         irq             <= 1'b0;
         status_ctrl_out <= 8'h00;
         ch_pin_owned    <= '0;
      end else begin
         ovf_irq         <= ovf_flag & sc_reg[`TRI_SC_OVF_IE];
         ch_irq          <= ch_req;
         irq             <= |(ist_reg & imask_reg);
         status_ctrl_out <= {ovf_flag, sc_reg[6:0]};
         for (int i = 0; i < N_CH; i++)
            ch_pin_owned[i] <= center | (|cc_reg[i][5:2]);
      end
   end

   always_ff @(posedge ref_clk or negedge srst_n) begin
      if (!srst_n) begin
         rdata <= 16'h0000;
      end else if (rd_stb) begin
         unique case (addr)
            `TRI_OFF_STATUS_CTRL: rdata <= {8'h00, ovf_flag, sc_reg[6:0]};
            `TRI_OFF_CH_CTRL0:    rdata <= {8'h00, ch_flag[0], cc_reg[0][6:0]};
            `TRI_OFF_CH_CTRL1:    rdata <= {8'h00, ch_flag[N_CH-1], cc_reg[N_CH-1][6:0]};
            `TRI_OFF_CH_FLAGS:    rdata <= 16'(ch_flag);
            `TRI_OFF_MODULO:      rdata <= mod_reg;
            `TRI_OFF_IRQ_STATUS:  rdata <= 16'(ist_reg);
            `TRI_OFF_IRQ_MASK:    rdata <= 16'(imask_reg);
            default:              rdata <= 16'h0000;
         endcase
      end else begin
         rdata <= 16'h0000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   property p_reset_quiet;
      @(posedge ref_clk) $rose(srst_n) |-> sc_reg == 8'h00 && !ovf_irq;
   endproperty
   a_reset_quiet: assert property (p_reset_quiet) else $error("control not clear after reset");

   property p_reset_channels;
      @(posedge ref_clk) $rose(srst_n) |-> cc_reg[0] == 8'h00 && !center;
   endproperty
   a_reset_channels: assert property (p_reset_channels) else $error("channel bits not clear");

   property p_ovf_gate;
      @(posedge ref_clk) disable iff (!srst_n)
         ovf_irq |-> $past(ovf_flag && sc_reg[`TRI_SC_OVF_IE]);
   endproperty
   a_ovf_gate: assert property (p_ovf_gate) else $error("overflow request without enable");

   property p_ovf_level;
      @(posedge ref_clk) disable iff (!srst_n)
         (ovf_flag && sc_reg[`TRI_SC_OVF_IE]) |=> ovf_irq;
   endproperty
   a_ovf_level: assert property (p_ovf_level) else $error("overflow request dropped");

   property p_ch_level;
      @(posedge ref_clk) disable iff (!srst_n)
         (ch_flag[0] && cc_reg[0][`TRI_CC_IE]) |=> ch_irq[0];
   endproperty
   a_ch_level: assert property (p_ch_level) else $error("channel request dropped");

   property p_edge_ovf;
      @(posedge ref_clk) disable iff (!srst_n)
         (!center && running && cnt_prev_reg == term && count == 16'h0000) |=> ovf_flag;
   endproperty
   a_edge_ovf: assert property (p_edge_ovf) else $error("overflow missed at wrap");

   property p_capture;
      @(posedge ref_clk) disable iff (!srst_n)
         (!center && cc_reg[0][5:4] == 2'b00 && cc_reg[0][`TRI_CC_ELS_LO] && ch_pin[0] && !pin_prev_reg[0])
            |=> ch_flag[0];
   endproperty
   a_capture: assert property (p_capture) else $error("capture edge missed");

   property p_compare;
      @(posedge ref_clk) disable iff (!srst_n)
         (!center && cc_reg[N_CH-1][5:4] == 2'b01 && running && count != cnt_prev_reg
            && count == ch_value[N_CH*16-1 -: 16]) |=> ch_flag[N_CH-1];
   endproperty
   a_compare: assert property (p_compare) else $error("compare match missed");

   property p_write_one;
      @(posedge ref_clk) disable iff (!srst_n)
         (wr_chf && wdata[0] && ch_flag[0]) |=> ch_flag[0];
   endproperty
   a_write_one: assert property (p_write_one) else $error("writing one cleared flag");

   property p_center_ovf;
      @(posedge ref_clk) disable iff (!srst_n)
         (center && running && $past(count, 2) < term && $past(count) == term && count < term) |=> ovf_flag;
   endproperty
   a_center_ovf: assert property (p_center_ovf) else $error("overflow missed at reversal");

   c_ovf_irq:  cover property (@(posedge ref_clk) disable iff (!srst_n) $rose(ovf_irq));
   c_ch_clear: cover property (@(posedge ref_clk) disable iff (!srst_n) $fell(ch_flag[0]));
   c_summary:  cover property (@(posedge ref_clk) disable iff (!srst_n) $rose(irq));
endmodule

// file: testbench/timer_reset_and_interrupt_flags_test.sv
// self-checking bench for the timer flag block
`timescale 1ns/1ns
module timer_reset_and_interrupt_flags_test;
   localparam int N_CH = 2;
   logic        ref_clk;
   logic        rst_n;
   logic [3:0]  addr;
   logic [15:0] wdata;
   logic        wr_stb;
   logic        rd_stb;
   logic [15:0] rdata;
   logic [15:0] count;
   logic [1:0]  ch_pin;
   logic [31:0] ch_value;
   logic        ovf_irq;
   logic [1:0]  ch_irq;
   logic        irq;
   logic [7:0]  sc_out;
   logic [1:0]  pin_owned;
   logic [3:0]  pend;
   logic        rd_q = 1'b0;
   logic [31:0] notes[$];
   int          n_errors;
   int          cmp_count;
   logic [15:0] modv;
   logic [15:0] chv;

   tri_timer_flags #(
      .N_CH (N_CH)
   ) i_dut (
      .ref_clk         (ref_clk),
      .rst_n           (rst_n),
      .addr            (addr),
      .wdata           (wdata),
      .wr_stb          (wr_stb),
      .rd_stb          (rd_stb),
      .rdata           (rdata),
      .count           (count),
      .ch_pin          (ch_pin),
      .ch_value        (ch_value),
      .ovf_irq         (ovf_irq),
      .ch_irq          (ch_irq),
      .irq             (irq),
      .status_ctrl_out (sc_out),
      .ch_pin_owned    (pin_owned)
   );

   tri_intc_model #(
      .N_CH (N_CH)
   ) i_intc (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .ovf_irq (ovf_irq),
      .ch_irq  (ch_irq),
      .irq     (irq),
      .pend    (pend)
   );

   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////
   task automatic fail(input string msg);
      n_errors++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
   endtask

   task automatic chk_sig(input logic [15:0] got, input logic [15:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         fail(what);
      end
   endtask

   task automatic chk_rd(input logic [15:0] got);
      logic [31:0] n;
      cmp_count++;
      if (notes.size() == 0) begin
         fail("read data without a read");
      end else begin
         n = notes.pop_front();
         if ((got & n[31:16]) !== n[15:0]) begin
            fail("read data");
         end
      end
   endtask

   // read data stand only in the cycle after the strobe
   always @(posedge ref_clk) begin
      if (rd_q) begin
         chk_rd(rdata);
      end
      rd_q <= rd_stb;
   end

   ////////////////////////////////////////
   task automatic bus(input logic w, input logic r, input logic [3:0] a, input logic [15:0] d);
      addr   <= a;
      wdata  <= d;
      wr_stb <= w;
      rd_stb <= r;
      @(posedge ref_clk);
   endtask

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      bus(1'b1, 1'b0, a, d);
   endtask

   task automatic rd(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
      notes.push_back({m, e & m});
      bus(1'b0, 1'b1, a, 16'h0000);
   endtask

   task automatic drive(input logic [15:0] c, input logic [1:0] p);
      count  <= c;
      ch_pin <= p;
      bus(1'b0, 1'b0, addr, wdata);
   endtask

   // idle cycles, then let the edge's updates land
   task automatic tick(input int n);
      repeat (n) drive(count, ch_pin);
      #1;
   endtask

   task automatic release_reset();
      tick(3);
      rst_n <= 1'b1;
      tick(3);
   endtask

   task automatic done(input string s);
      $display("test %s finished", s);
   endtask

   task automatic finish_test();
      $display("compares %0d errors %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge ref_clk);
      fail("run did not finish");
      finish_test();
   end

   ////////////////////////////////////////
   initial begin
      void'($urandom(34));
      n_errors = 0;
      cmp_count = 0;
      rst_n = 1'b0;
      addr = 4'h0;
      wdata = 16'h0000;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      count = 16'h0000;
      ch_pin = 2'b00;
      ch_value = {16'h0000, 16'($urandom)};
      modv = 16'h0100 + 16'($urandom_range(16'h3F00));
      chv = 16'h0400 + 16'($urandom_range(16'h3000));
      #1;
      release_reset();
      rd(4'h0, 16'h0000, 16'hFFFF);
      rd(4'h1, 16'h0000, 16'hFFFF);
      rd(4'h2, 16'h0000, 16'hFFFF);
      rd(4'hF, 16'h0000, 16'hFFFF);
      tick(2);
      chk_sig(16'(sc_out), 16'h0000, "status copy after reset");
      chk_sig(16'(pin_owned), 16'h0000, "pins not released");
      done("reset");
      // overflow at modulo terminal, then read-then-write-zero clearing
      wr(4'h4, modv);
      wr(4'hF, 16'hFFFF);
      wr(4'h0, 16'h0048);
      drive(modv - 16'h0001, 2'b00);
      drive(modv, 2'b00);
      tick(2);
      chk_sig(16'(ovf_irq), 16'h0000, "overflow too early");
      drive(16'h0000, 2'b00);
      tick(2);
      chk_sig(16'(ovf_irq), 16'h0001, "overflow request");
      chk_sig(16'(pend[0]), 16'h0001, "controller sees overflow");
      rd(4'h0, 16'h00C8, 16'hFFFF);
      wr(4'h0, 16'h00C8);
      tick(2);
      chk_sig(16'(ovf_irq), 16'h0001, "write of one cleared flag");
      rd(4'h0, 16'h0080, 16'h0080);
      drive(modv, 2'b00);
      drive(16'h0000, 2'b00);
      wr(4'h0, 16'h0048);
      tick(2);
      chk_sig(16'(sc_out), 16'h00C8, "clear not cancelled");
      rd(4'h0, 16'h0080, 16'h0080);
      wr(4'h0, 16'h0048);
      tick(3);
      chk_sig(16'(ovf_irq), 16'h0000, "flag not cleared");
      chk_sig(16'(pend[0]), 16'h0000, "request still held");
      wr(4'h4, 16'h0000);
      drive(16'hFFFF, 2'b00);
      drive(16'h0000, 2'b00);
      tick(2);
      rd(4'h0, 16'h0080, 16'h0080);
      wr(4'h0, 16'h0048);
      done("overflow");
      wr(4'h4, modv);
      wr(4'h0, 16'h0068);
      drive(modv - 16'h0002, 2'b00);
      drive(modv - 16'h0001, 2'b00);
      tick(2);
      rd(4'h0, 16'h0000, 16'h0080);
      drive(modv, 2'b00);
      drive(modv - 16'h0001, 2'b00);
      tick(2);
      rd(4'h0, 16'h0080, 16'h0080);
      done("center overflow");
      // reset in mid-run with a flag pending and center mode on
      // let the last read data be checked before reset clears them
      tick(1);
      rst_n <= 1'b0;
      release_reset();
      rd(4'h0, 16'h0000, 16'hFFFF);
      tick(1);
      chk_sig(16'(ovf_irq), 16'h0000, "overflow request after reset");
      wr(4'h0, 16'h0008);
      for (int e = 0; e < 4; e++) begin
         wr(4'h1, 16'h0040 | 16'(e << 2));
         tick(2);
         chk_sig(16'(pin_owned[0]), 16'(e != 0), "pin ownership");
         drive(count, 2'b01);
         tick(2);
         chk_sig(16'(ch_irq[0]), 16'(e & 1), "rising capture request");
         rd(4'h3, 16'(e & 1), 16'h0001);
         wr(4'h3, 16'h0001);
         wr(4'h3, 16'h0000);
         drive(count, 2'b00);
         tick(2);
         rd(4'h3, 16'(e >> 1), 16'h0001);
         wr(4'h3, 16'h0000);
      end
      done("capture");
      ch_value[31:16] <= chv;
      for (int i = 0; i < 3; i++) begin
         wr(4'h0, (i == 2) ? 16'h0028 : 16'h0008);
         wr(4'h2, (i == 0) ? 16'h0050 : 16'h0020);
         drive(chv - 16'h0001, 2'b00);
         drive(chv, 2'b00);
         tick(2);
         chk_sig(16'(ch_irq[1]), 16'(i == 0), "channel request gating");
         rd(4'h3, 16'h0002, 16'h0002);
         wr(4'h3, 16'h0000);
         tick(2);
         rd(4'h3, 16'h0000, 16'h0002);
         if (i == 2) begin
            drive(chv + 16'h0001, 2'b00);
            drive(chv, 2'b00);
            tick(2);
            rd(4'h3, 16'h0002, 16'h0002);
         end
      end
      done("compare and pwm");
      chk_sig(16'(irq), 16'h0000, "summary while masked");
      wr(4'h6, 16'h0004);
      tick(2);
      chk_sig(16'(irq), 16'h0001, "summary request");
      chk_sig(16'(pend[3]), 16'h0001, "controller sees summary");
      rd(4'h6, 16'h0004, 16'hFFFF);
      wr(4'h5, 16'h0004);
      tick(2);
      chk_sig(16'(irq), 16'h0000, "summary after clear");
      rd(4'h5, 16'h0002, 16'h0006);
      tick(3);
      done("summary");
      chk_sig(16'(notes.size()), 16'h0000, "reads left unanswered");
      finish_test();
   end
endmodule

// file: testbench/tri_intc_model.sv
// interrupt controller stand-in for the timer flag block
`timescale 1ns/1ns
module tri_intc_model #(
   parameter int N_CH = 2
)
(
   input  wire logic            ref_clk,
   input  wire logic            rst_n,
   input  wire logic            ovf_irq,
   input  wire logic [N_CH-1:0] ch_irq,
   input  wire logic            irq,
   output logic      [N_CH+1:0] pend
);
   // level sensitive, high true: a request counts only while held
   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         pend <= '0;
      end else begin
         pend <= {irq, ch_irq, ovf_irq};
      end
   end
endmodule
